// [rtl/flash_bus_command_front_end.sv]
// Purpose: host controller that drives a 128K x 8 flash through its asynchronous pins
// Assumes: pins synchronous to mclk; one request at a time; device finishes its own operations
// Notes: program/erase requests are sequenced with unlock cycles; status polling is left to the user
`default_nettype none
module flash_bus_command_front_end
	import flash_host_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// user request
	input wire flash_host_pkg::req_t req,
	input wire logic req_valid,
	output logic req_ready,
	output logic [7:0] rsp_data,
	output logic rsp_valid,
	// flash pins
	output flash_host_pkg::pins_t pins,
	input wire logic [7:0] dq_in
);
	import flash_host_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000, ST_SETUP = 3'b001, ST_PULSE = 3'b011, ST_RECOVER = 3'b010,
		ST_READ = 3'b110, ST_DONE = 3'b111
	} state_t;

	// one step of a command sequence: address/data of cycle idx, or the reset write for idx 6 and above
	function automatic logic [24:0] seq_step(input req_t r, input logic [2:0] idx);
		logic [16:0] sect;
		sect = {r.addr[SECTOR_HI:SECTOR_LO], 14'h0000};
		case (idx)
			3'h0: seq_step = {UNLOCK_ADDR1, UNLOCK_DATA1};
			3'h1: seq_step = {UNLOCK_ADDR2, UNLOCK_DATA2};
			3'h2: begin
				case (r.op)
					OP_PROGRAM: seq_step = {UNLOCK_ADDR1, CMD_PROGRAM};
					OP_SECT_ERASE, OP_CHIP_ERASE: seq_step = {UNLOCK_ADDR1, CMD_ERASE_SETUP};
					default: seq_step = {UNLOCK_ADDR1, CMD_AUTOSEL};
				endcase
			end
			3'h3: begin
				if (r.op == OP_PROGRAM) begin
					seq_step = {r.addr, r.data};
				end else begin
					seq_step = {UNLOCK_ADDR1, UNLOCK_DATA1};
				end
			end
			3'h4: seq_step = {UNLOCK_ADDR2, UNLOCK_DATA2};
			3'h5: begin
				if (r.op == OP_CHIP_ERASE) begin
					seq_step = {UNLOCK_ADDR1, CMD_CHIP_ERASE};
				end else begin
					seq_step = {sect, CMD_SECTOR_ERASE};
				end
			end
			default: seq_step = {17'h00000, CMD_RESET};
		endcase
	endfunction

	// number of write cycles per operation; zero means a plain read
	function automatic logic [2:0] seq_len(input op_t op);
		case (op)
			OP_READ: seq_len = 3'h0;
			OP_RESET: seq_len = 3'h1;
			OP_PROGRAM: seq_len = 3'h4;
			OP_SECT_ERASE, OP_CHIP_ERASE: seq_len = 3'h6;
			default: seq_len = 3'h3;
		endcase
	endfunction

	state_t state_r, state_nxt;
	req_t req_r, req_nxt;
	pins_t pins_r, pins_nxt;
	logic [2:0] idx_r, idx_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic [7:0] rsp_data_r, rsp_data_nxt;
	logic rsp_valid_r, rsp_valid_nxt;
	logic ready_r;
	logic [16:0] rd_addr;

	// address of the closing read for identifier operations
	always_comb begin
		case (req_r.op)
			OP_ID_MFR: rd_addr = ID_MFR_ADDR;
			OP_ID_DEV: rd_addr = ID_DEV_ADDR;
			OP_PROT_CHECK: rd_addr = {req_r.addr[SECTOR_HI:SECTOR_LO], 14'h0000} | ID_PROT_OFS;
			default: rd_addr = req_r.addr;
		endcase
	end

	// sequencer: each write cycle is setup, pulse, recover; then an optional read
	always_comb begin
		state_nxt = state_r;
		req_nxt = req_r;
		pins_nxt = pins_r;
		idx_nxt = idx_r;
		rsp_data_nxt = rsp_data_r;
		rsp_valid_nxt = 1'b0;
		cnt_nxt = (cnt_r == CNT_ZERO) ? CNT_ZERO : cnt_r - 8'h01;
		case (state_r)
			ST_IDLE: begin
				pins_nxt.ce_n = 1'b1;
				pins_nxt.oe_n = 1'b1;
				pins_nxt.we_n = 1'b1;
				pins_nxt.dq_oe = 1'b0;
				// ready is low on the first edge after reset, so a request there is refused
				if (req_valid && ready_r) begin
					req_nxt = req;
					idx_nxt = 3'h0;
					cnt_nxt = 8'(SETUP_CYC);
					state_nxt = (seq_len(req.op) == 3'h0) ? ST_READ : ST_SETUP;
					if (seq_len(req.op) == 3'h0) begin
						// read: chip enable and output gate low, write enable high
						pins_nxt.addr = req.addr;
						pins_nxt.ce_n = 1'b0;
						pins_nxt.oe_n = 1'b0;
						cnt_nxt = 8'(ACCESS_CYC);
					end
				end
			end
			ST_SETUP: begin
				// address and data settle with output gate high before the pulse
				{pins_nxt.addr, pins_nxt.dq_out} = seq_step(req_r, idx_r);
				pins_nxt.dq_oe = 1'b1;
				pins_nxt.oe_n = 1'b1;
				pins_nxt.ce_n = 1'b0;
				if (cnt_r == CNT_ZERO) begin
					pins_nxt.we_n = 1'b0;
					cnt_nxt = 8'(WPULSE_CYC);
					state_nxt = ST_PULSE;
				end
			end
			ST_PULSE: begin
				// pulse is held well past the glitch filter width
				if (cnt_r == CNT_ZERO) begin
					pins_nxt.we_n = 1'b1;
					cnt_nxt = 8'(RECOVER_CYC);
					state_nxt = ST_RECOVER;
				end
			end
			ST_RECOVER: begin
				if (cnt_r == CNT_ZERO) begin
					pins_nxt.ce_n = 1'b1;
					pins_nxt.dq_oe = 1'b0;
					idx_nxt = idx_r + 3'h1;
					if (idx_r + 3'h1 < seq_len(req_r.op)) begin
						cnt_nxt = 8'(SETUP_CYC);
						state_nxt = ST_SETUP;
					end else if (req_r.op inside {OP_ID_MFR, OP_ID_DEV, OP_PROT_CHECK}) begin
						pins_nxt.addr = rd_addr;
						pins_nxt.ce_n = 1'b0;
						pins_nxt.oe_n = 1'b0;
						cnt_nxt = 8'(ACCESS_CYC);
						state_nxt = ST_READ;
					end else begin
						state_nxt = ST_DONE;
					end
				end
			end
			ST_READ: begin
				if (cnt_r == CNT_ZERO) begin
					rsp_data_nxt = dq_in;
					rsp_valid_nxt = 1'b1;
					pins_nxt.ce_n = 1'b1;
					pins_nxt.oe_n = 1'b1;
					// identifier reads leave autoselect by writing reset
					if (req_r.op inside {OP_ID_MFR, OP_ID_DEV, OP_PROT_CHECK}) begin
						req_nxt.op = OP_RESET;
						idx_nxt = 3'h6;
						cnt_nxt = 8'(SETUP_CYC);
						state_nxt = ST_SETUP;
					end else begin
						state_nxt = ST_DONE;
					end
				end
			end
			ST_DONE: begin
				if (req_r.op != OP_READ && req_r.op inside {OP_PROGRAM, OP_SECT_ERASE, OP_CHIP_ERASE, OP_RESET}) begin
					rsp_valid_nxt = 1'b1;
					rsp_data_nxt = 8'h00;
				end
				state_nxt = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase
		// reset sequence is one cycle starting at index 6
		if (state_r == ST_IDLE && req_valid && ready_r && req.op == OP_RESET) begin
			idx_nxt = 3'h6;
		end
	end

	// registers; pins come up idle, so power-up never looks like a write
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_r <= ST_IDLE;
			req_r <= '0;
			pins_r <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 17'h00000, dq_out: 8'h00, dq_oe: 1'b0};
			idx_r <= 3'h0;
			cnt_r <= CNT_ZERO;
			rsp_data_r <= 8'h00;
			rsp_valid_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			req_r <= req_nxt;
			pins_r <= pins_nxt;
			idx_r <= idx_nxt;
			cnt_r <= cnt_nxt;
			rsp_data_r <= rsp_data_nxt;
			rsp_valid_r <= rsp_valid_nxt;
		end
	end

	// ready is registered from the next state, so it matches the state register after the first edge
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ready_r <= 1'b0;
		end else begin
			ready_r <= (state_nxt == ST_IDLE);
		end
	end
	assign req_ready = ready_r;
	assign pins = pins_r;
	assign rsp_data = rsp_data_r;
	assign rsp_valid = rsp_valid_r;

	// checks on the pin discipline and the response handshake, plus cover points for the main sequences
	chk_write_oe_high: assert property (@(posedge mclk) disable iff (!resetn)
		!pins_r.we_n |-> (pins_r.oe_n && !pins_r.ce_n)) else $error("write with bad control levels");
	chk_pulse_width: assert property (@(posedge mclk) disable iff (!resetn)
		$fell(pins_r.we_n) |=> !pins_r.we_n) else $error("write pulse too short");
	chk_read_we_high: assert property (@(posedge mclk) disable iff (!resetn)
		!pins_r.oe_n |-> (pins_r.we_n && !pins_r.ce_n && !pins_r.dq_oe)) else $error("read with bad levels");
	chk_access_wait: assert property (@(posedge mclk) disable iff (!resetn)
		$fell(pins_r.oe_n) |-> !rsp_valid_r[*3]) else $error("read data taken early");
	chk_standby_float: assert property (@(posedge mclk) disable iff (!resetn)
		pins_r.ce_n |-> (!pins_r.dq_oe && pins_r.we_n)) else $error("drive in standby");
	chk_drive_stable: assert property (@(posedge mclk) disable iff (!resetn)
		!pins_r.we_n && $past(!pins_r.we_n) |-> $stable(pins_r.dq_out) && $stable(pins_r.addr)) else $error("bus moved in pulse");
	chk_done_in_time: assert property (@(posedge mclk) disable iff (!resetn)
		(state_r == ST_READ && cnt_r == CNT_ZERO) |=> rsp_valid_r) else $error("read answer missing");
	chk_idle_ready: assert property (@(posedge mclk) disable iff (!resetn)
		rsp_valid_r |-> ##[1:40] req_ready) else $error("controller stuck");
	cov_program: cover property (@(posedge mclk) disable iff (!resetn) state_r == ST_SETUP && req_r.op == OP_PROGRAM && idx_r == 3'h3);
	cov_chip_erase: cover property (@(posedge mclk) disable iff (!resetn) state_r == ST_SETUP && req_r.op == OP_CHIP_ERASE && idx_r == 3'h5);
	cov_id_read: cover property (@(posedge mclk) disable iff (!resetn) rsp_valid_r && state_r == ST_SETUP);
	cov_array_read: cover property (@(posedge mclk) disable iff (!resetn) rsp_valid_r && req_r.op == OP_READ);
endmodule // flash_bus_command_front_end
`default_nettype wire

// [rtl/flash_host_pkg.sv]
// Purpose: constants and carrier types for the parallel flash bus controller
// Assumes: 40 MHz mclk, 17-bit address, 8-bit data
// Notes: unlock addresses and command bytes are plain defaults, set for the target part
`default_nettype none
package flash_host_pkg;
	localparam int ADDR_W = 17;
	localparam int DATA_W = 8;
	localparam int SECTOR_HI = 16;
	localparam int SECTOR_LO = 14;
	localparam int CLK_PERIOD_NS = 25;
	// access and pulse times, in ns
	localparam int T_ACCESS_NS = 45;
	localparam int T_WPULSE_NS = 35;
	localparam int T_RECOVER_NS = 20;
	localparam int T_SETUP_NS = 10;
	localparam int T_GLITCH_NS = 5;
	localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int WPULSE_CYC = (T_WPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GLITCH_CYC = (T_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] CNT_ZERO = 8'h00;
	// command sequence values
	localparam logic [16:0] UNLOCK_ADDR1 = 17'h00555;
	localparam logic [16:0] UNLOCK_ADDR2 = 17'h002AA;
	localparam logic [7:0] UNLOCK_DATA1 = 8'hAA;
	localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
	localparam logic [7:0] CMD_AUTOSEL = 8'h90;
	localparam logic [7:0] CMD_PROGRAM = 8'hA0;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] CMD_RESET = 8'hF0;
	localparam logic [16:0] ID_MFR_ADDR = 17'h00000;
	localparam logic [16:0] ID_DEV_ADDR = 17'h00001;
	localparam logic [16:0] ID_PROT_OFS = 17'h00002;
	localparam logic [2:0] SECT_ZERO = 3'h0;
	// host operations
	typedef enum logic [2:0] {
		OP_READ = 3'h0, OP_PROGRAM = 3'h1, OP_SECT_ERASE = 3'h2, OP_CHIP_ERASE = 3'h3,
		OP_ID_MFR = 3'h4, OP_ID_DEV = 3'h5, OP_PROT_CHECK = 3'h6, OP_RESET = 3'h7
	} op_t;
	typedef struct packed {
		op_t op;
		logic [16:0] addr;
		logic [7:0] data;
	} req_t;
	// pin group toward the flash
	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic [16:0] addr;
		logic [7:0] dq_out;
		logic dq_oe;
	} pins_t;
endpackage : flash_host_pkg
`default_nettype wire

// [sim/flash_bus_command_front_end_test.sv]
// Purpose: self-checking bench for the flash host controller
// Assumes: inputs driven at the falling edge; one request at a time
// Notes: expected bytes queue up at request time and are matched per response
`default_nettype none
module flash_bus_command_front_end_test;
	timeunit 1ns;
	timeprecision 100ps;
	import flash_host_pkg::*;
	localparam logic [7:0] MFR_CODE = 8'hC3; // arbitrary value
	localparam logic [7:0] DEV_CODE = 8'h7E; // arbitrary value
	logic mclk = 1'b0, resetn = 1'b0, req_valid = 1'b0, req_ready, rsp_valid;
	req_t req = '0;
	pins_t pins;
	logic [7:0] rsp_data, dq_in;
	logic [7:0] prot_mask = 8'h00;
	logic [7:0] exp_q [$];
	int error_cnt = 0, check_count = 0;
	logic [31:0] rng = 32'h16;
	always #12.5 mclk = ~mclk;
	flash_bus_command_front_end u_dut (.mclk(mclk), .resetn(resetn), .req(req), .req_valid(req_valid),
		.req_ready(req_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid), .pins(pins), .dq_in(dq_in));
	flash_dev_model #(.MFR_CODE(MFR_CODE), .DEV_CODE(DEV_CODE), .BUSY_NS(1000)) u_flash (.pins(pins),
		.prot_mask(prot_mask), .dq(dq_in));
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// one request, held until the edge that takes it
	task automatic do_req(input op_t op, input logic [16:0] a, input logic [7:0] d, input logic [7:0] exp);
		repeat (400) if (req_ready !== 1'b1) @(negedge mclk);
		req = '{op: op, addr: a, data: d};
		req_valid = 1'b1;
		exp_q.push_back(exp);
		// identifier ops answer twice: the code, then the automatic reset write
		if (op inside {OP_ID_MFR, OP_ID_DEV, OP_PROT_CHECK}) exp_q.push_back(8'h00);
		@(negedge mclk);
		req_valid = 1'b0;
	endtask
	// write-type request, then out-wait the device busy time
	task automatic prog_wait(input op_t op, input logic [16:0] a, input logic [7:0] d);
		do_req(op, a, d, 8'h00);
		// six-cycle erase sequences plus the busy time need about 80 cycles
		repeat (90) @(negedge mclk);
	endtask
	task automatic end_test(input string name);
		repeat (400) if (exp_q.size() != 0) @(negedge mclk);
		$display("test %s done", name);
	endtask
	// response watcher, oldest note first
	always @(negedge mclk) begin
		if (rsp_valid === 1'b1) begin
			if (exp_q.size() == 0) check_byte("unexpected rsp_valid", 8'h00, rsp_data);
			else check_byte("rsp_data", exp_q.pop_front(), rsp_data);
		end
	end
	initial begin
		#(40000 * CLK_PERIOD_NS);
		error_cnt++;
		$display("MISMATCH watchdog expected done seen timeout");
		finish_test();
	end
	initial begin
		logic [16:0] a;
		logic [7:0] d;
		repeat (8) @(negedge mclk);
		resetn = 1'b1;
		repeat (2) @(negedge mclk);
		// erased array, back to back random reads
		for (int i = 0; i < 4; i++) begin
			rng = next_rand(rng);
			do_req(OP_READ, rng[16:0], 8'h00, 8'hFF);
		end
		end_test("erased reads");
		rng = next_rand(rng);
		a = {3'h0, rng[13:0]};
		d = rng[23:16];
		do_req(OP_PROGRAM, a, d, 8'h00);
		do_req(OP_READ, a, 8'h00, {~d[7], 7'h00});
		repeat (60) @(negedge mclk);
		do_req(OP_READ, a, 8'h00, d);
		end_test("program");
		prot_mask = 8'h04;
		do_req(OP_ID_MFR, 17'h00000, 8'h00, MFR_CODE);
		do_req(OP_ID_DEV, 17'h00000, 8'h00, DEV_CODE);
		do_req(OP_PROT_CHECK, 17'h08000, 8'h00, 8'h01);
		do_req(OP_PROT_CHECK, 17'h0C000, 8'h00, 8'h00);
		do_req(OP_READ, a, 8'h00, d);
		end_test("autoselect");
		prog_wait(OP_PROGRAM, 17'h08010, 8'h00);
		do_req(OP_READ, 17'h08010, 8'h00, 8'hFF);
		prot_mask = 8'h00;
		prog_wait(OP_PROGRAM, 17'h08010, 8'h00);
		do_req(OP_READ, 17'h08010, 8'h00, 8'h00);
		end_test("protection");
		prog_wait(OP_PROGRAM, 17'h0C020, 8'h5A);
		prog_wait(OP_SECT_ERASE, 17'h08000, 8'h00);
		do_req(OP_READ, 17'h08010, 8'h00, 8'hFF);
		do_req(OP_READ, 17'h0C020, 8'h00, 8'h5A);
		prog_wait(OP_CHIP_ERASE, 17'h00000, 8'h00);
		do_req(OP_READ, 17'h0C020, 8'h00, 8'hFF);
		do_req(OP_READ, a, 8'h00, 8'hFF);
		do_req(OP_RESET, 17'h00000, 8'h00, 8'h00);
		do_req(OP_READ, a, 8'h00, 8'hFF);
		end_test("erase and reset");
		finish_test();
	end
endmodule // flash_bus_command_front_end_test
`default_nettype wire

// [sim/flash_dev_model.sv]
// Purpose: behavioural parallel flash device facing the host controller
// Assumes: pins are levels; a write ends at the first rising strobe edge
// Notes: busy time is a short parameter, far below real embedded algorithm times
`default_nettype none
module flash_dev_model
	import flash_host_pkg::*;
#(
	parameter logic [7:0] MFR_CODE = 8'hC3, // arbitrary value
	parameter logic [7:0] DEV_CODE = 8'h7E, // arbitrary value
	parameter int BUSY_NS = 1000
) (
	// pins from the controller
	input wire flash_host_pkg::pins_t pins,
	input wire logic [7:0] prot_mask,
	// data toward the controller
	output logic [7:0] dq
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [0:131071];
	logic [16:0] lat_addr;
	logic [7:0] rd_val, last_d;
	logic asel, busy, wr_open;
	int step;
	realtime fall_t;
	// power-up lands in array read with an erased array
	initial begin
		foreach (mem[i]) mem[i] = 8'hFF;
		asel = 1'b0; busy = 1'b0; wr_open = 1'b0; step = 0; fall_t = 0; last_d = 8'h00; lat_addr = '0;
	end
	// command decoder; any unexpected cycle drops back to step 0, autoselect is left only on a reset byte
	task automatic cmd(input logic [16:0] a, input logic [7:0] d);
		logic u1, u2;
		u1 = (a == UNLOCK_ADDR1) && (d == UNLOCK_DATA1);
		u2 = (a == UNLOCK_ADDR2) && (d == UNLOCK_DATA2);
		case (step)
			0: begin
				if (d == CMD_RESET) asel = 1'b0;
				step = u1 ? 1 : 0;
			end
			1, 5: step = u2 ? step + 1 : 0;
			4: step = u1 ? 5 : 0;
			2: begin
				step = (a != UNLOCK_ADDR1) ? 0 : (d == CMD_PROGRAM) ? 3 : (d == CMD_ERASE_SETUP) ? 4 : 0;
				if (a == UNLOCK_ADDR1 && d == CMD_AUTOSEL) asel = 1'b1;
			end
			3: begin
				if (!prot_mask[a[16:14]]) mem[a] = mem[a] & d;
				last_d = d;
				busy = 1'b1;
				step = 0;
			end
			default: begin
				if (d == CMD_CHIP_ERASE) foreach (mem[i]) if (!prot_mask[i[16:14]]) mem[i] = 8'hFF;
				if (d == CMD_SECTOR_ERASE && !prot_mask[a[16:14]])
					for (int i = 0; i < 16384; i++) mem[{a[16:14], i[13:0]}] = 8'hFF;
				if (d == CMD_CHIP_ERASE || d == CMD_SECTOR_ERASE) busy = 1'b1;
				last_d = 8'hFF;
				step = 0;
			end
		endcase
	endtask
	// address at the later falling edge of the two strobes
	always @(negedge pins.we_n or negedge pins.ce_n) begin
		if (!pins.we_n && !pins.ce_n && pins.oe_n) begin
			lat_addr = pins.addr;
			fall_t = $realtime;
			wr_open = 1'b1;
		end
	end
	// data at the first rising edge; short glitches and busy time are ignored
	always @(posedge pins.we_n or posedge pins.ce_n) begin
		if (wr_open) begin
			wr_open = 1'b0;
			if (pins.oe_n && pins.dq_oe && ($realtime - fall_t >= 5.0) && !busy) cmd(lat_addr, pins.dq_out);
		end
	end
	// the operation runs out its time whether or not the chip stays selected
	always @(posedge busy) begin
		#(BUSY_NS);
		busy = 1'b0;
	end
	// status while busy, id codes in autoselect, else array data
	assign rd_val = busy ? {~last_d[7], 7'h00} : !asel ? mem[pins.addr] :
		(pins.addr[7:0] == ID_MFR_ADDR[7:0]) ? MFR_CODE : (pins.addr[7:0] == ID_DEV_ADDR[7:0]) ? DEV_CODE :
		(pins.addr[7:0] == ID_PROT_OFS[7:0]) ? {7'h00, prot_mask[pins.addr[16:14]]} : 8'h00;
	// released bus shows inverted data so a late sample never matches by luck
	assign dq = (!pins.ce_n && !pins.oe_n && pins.we_n) ? rd_val : ~rd_val;
endmodule // flash_dev_model
`default_nettype wire
